/* File: logic/status_flags.sv */
`timescale 1ns/1ps
module status_flags (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_N,
    // Instruction execution
    input wire logic EXEC_VALID,
    input wire status_pkg::alu_op_t ALU_OP,
    input wire logic [8:0] DEST_ADDR,
    input wire logic DEST_IS_REG,
    input wire logic [7:0] OPERAND_A,
    input wire logic [7:0] OPERAND_B,
    input wire logic [2:0] BIT_SEL,
    // Power events
    input wire logic WATCHDOG_KICK,
    input wire logic SLEEP_EXEC,
    input wire logic WATCHDOG_TIMEOUT,
    // Data address translation
    input wire logic [6:0] DIRECT_OFFSET,
    input wire logic [7:0] INDIRECT_PTR,
    // Outputs
    output logic [7:0] STATUS_VALUE,
    output logic [7:0] RESULT,
    output logic [8:0] DIRECT_ADDR,
    output logic [8:0] INDIRECT_ADDR
);
    import status_pkg::*;
    logic rst_meta_q;
    logic rst_sync_q;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] result_q;
    logic [7:0] result_d;
    logic [8:0] daddr_q;
    logic [8:0] daddr_d;
    logic [8:0] iaddr_q;
    logic [8:0] iaddr_d;
    logic [7:0] alu_result;
    logic [2:0] alu_flags;
    logic [2:0] alu_flag_en;
    logic hit;
    logic [7:0] wr_data;

    function automatic logic is_status_addr(input logic [8:0] a);
        is_status_addr = (a == STATUS_ADDR_BANK0) || (a == STATUS_ADDR_BANK1);
    endfunction

    // Reset release synchroniser
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Flag logic
    alu_flag_calc u_calc (
        .op(ALU_OP),
        .opnd_a(OPERAND_A),
        .opnd_b(OPERAND_B),
        .carry_in(status_q[BIT_CARRY]),
        .result(alu_result),
        .flags(alu_flags),
        .flag_en(alu_flag_en)
    );

    // Next status and result
    always_comb begin
        hit = EXEC_VALID && DEST_IS_REG && is_status_addr(DEST_ADDR);
        wr_data = alu_result;
        case (ALU_OP)
            OP_MOVE: wr_data = OPERAND_A;
            OP_SWAP: wr_data = {OPERAND_A[3:0], OPERAND_A[7:4]};
            OP_BIT_CLEAR: wr_data = OPERAND_A & ~(8'h01 << BIT_SEL);
            OP_BIT_SET: wr_data = OPERAND_A | (8'h01 << BIT_SEL);
            default: wr_data = alu_result;
        endcase
        status_d = status_q;
        result_d = EXEC_VALID ? wr_data : result_q;
        if (hit) begin
            status_d[7:5] = wr_data[7:5];
            if (alu_flag_en == 3'b000) begin
                status_d[2:0] = wr_data[2:0];
            end
        end
        if (EXEC_VALID) begin
            for (int i = 0; i < 3; i++) begin
                if (alu_flag_en[i]) begin
                    status_d[i] = alu_flags[i];
                end
            end
        end
        if (hit && ALU_OP == OP_CLEAR) begin
            status_d[7:5] = 3'b000;
            status_d[BIT_ZERO] = 1'b1;
        end
        if (WATCHDOG_KICK) begin
            status_d[BIT_TO] = 1'b1;
            status_d[BIT_PD] = 1'b1;
        end else if (SLEEP_EXEC) begin
            status_d[BIT_TO] = 1'b1;
            status_d[BIT_PD] = 1'b0;
        end
        if (WATCHDOG_TIMEOUT) begin
            status_d[BIT_TO] = 1'b0;
        end
        daddr_d = {status_d[BIT_RP_HI:BIT_RP_LO], DIRECT_OFFSET};
        iaddr_d = {status_d[BIT_IRP], INDIRECT_PTR};
    end

    // Register stage
    always_ff @(posedge CORE_CLK or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            status_q <= STATUS_RESET;
            result_q <= 8'h00;
            daddr_q <= 9'h000;
            iaddr_q <= 9'h000;
        end else begin
            status_q <= status_d;
            result_q <= result_d;
            daddr_q <= daddr_d;
            iaddr_q <= iaddr_d;
        end
    end

    // Outputs from flops
    always_comb begin
        STATUS_VALUE = status_q;
        RESULT = result_q;
        DIRECT_ADDR = daddr_q;
        INDIRECT_ADDR = iaddr_q;
    end

    property p_wr_protect;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (hit && !WATCHDOG_KICK && !SLEEP_EXEC && !WATCHDOG_TIMEOUT)
            |=> $stable(status_q[4:3]);
    endproperty
    a_wr_protect: assert property (p_wr_protect) else $error("read-only flags changed");

    property p_clear;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (hit && ALU_OP == OP_CLEAR) |=> (status_q[7:5] == 3'b000 && status_q[BIT_ZERO]);
    endproperty
    a_clear: assert property (p_clear) else $error("clear pattern wrong");

    property p_sleep;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (SLEEP_EXEC && !WATCHDOG_KICK) |=> !status_q[BIT_PD];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep did not clear powerdown");

    property p_timeout;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        WATCHDOG_TIMEOUT |=> !status_q[BIT_TO];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not cleared");

    property p_kick;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (WATCHDOG_KICK && !WATCHDOG_TIMEOUT) |=> status_q[4:3] == 2'b11;
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not set flags");

    property p_zero;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ADD) |=> status_q[BIT_ZERO] == (RESULT == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag mismatch");

    property p_carry;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ADD) |=> status_q[BIT_CARRY] ==
            (({1'b0, $past(OPERAND_A)} + {1'b0, $past(OPERAND_B)}) > 9'h0ff);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag mismatch");

    property p_rot;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ROT_RIGHT) |=> status_q[BIT_CARRY] == $past(OPERAND_A[0]);
    endproperty
    a_rot: assert property (p_rot) else $error("rotate carry wrong");

    property p_bank;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        1'b1 |=> DIRECT_ADDR[8:7] == status_q[6:5];
    endproperty
    a_bank: assert property (p_bank) else $error("bank select mismatch");

    property p_rot_left;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ROT_LEFT) |=> status_q[BIT_CARRY] == $past(OPERAND_A[7]);
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left carry wrong");

    property p_rot_res;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ROT_RIGHT)
            |=> RESULT == {$past(status_q[BIT_CARRY]), $past(OPERAND_A[7:1])};
    endproperty
    a_rot_res: assert property (p_rot_res) else $error("rotate result wrong");

    property p_sub_carry;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_SUB)
            |=> status_q[BIT_CARRY] == ($past(OPERAND_A) >= $past(OPERAND_B));
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("subtract borrow wrong");

    property p_sub_nibble;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_SUB)
            |=> status_q[BIT_NIBBLE] == ($past(OPERAND_A[3:0]) >= $past(OPERAND_B[3:0]));
    endproperty
    a_sub_nibble: assert property (p_sub_nibble) else $error("nibble borrow wrong");

    property p_add_nibble;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ADD) |=> status_q[BIT_NIBBLE] ==
            (({1'b0, $past(OPERAND_A[3:0])} + {1'b0, $past(OPERAND_B[3:0])}) > 5'h0f);
    endproperty
    a_add_nibble: assert property (p_add_nibble) else $error("nibble carry wrong");

    property p_clear_keep;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (hit && ALU_OP == OP_CLEAR) |=> $stable(status_q[1:0]);
    endproperty
    a_clear_keep: assert property (p_clear_keep) else $error("clear changed carries");

    property p_move_write;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (hit && ALU_OP == OP_MOVE)
            |=> status_q[7:5] == $past(OPERAND_A[7:5]) && status_q[2:0] == $past(OPERAND_A[2:0]);
    endproperty
    a_move_write: assert property (p_move_write) else $error("store write wrong");

    property p_swap_write;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (hit && ALU_OP == OP_SWAP)
            |=> status_q[7:5] == $past(OPERAND_A[3:1]) && status_q[2:0] == $past(OPERAND_A[6:4]);
    endproperty
    a_swap_write: assert property (p_swap_write) else $error("swap write wrong");

    property p_indirect;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        1'b1 |=> INDIRECT_ADDR[8] == status_q[BIT_IRP];
    endproperty
    a_indirect: assert property (p_indirect) else $error("indirect bank mismatch");

    property p_direct_low;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        rst_sync_q |=> DIRECT_ADDR[6:0] == $past(DIRECT_OFFSET);
    endproperty
    a_direct_low: assert property (p_direct_low) else $error("direct offset mismatch");

    property p_other_addr;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && !hit && ALU_OP == OP_MOVE)
            |=> $stable(status_q[7:5]) && $stable(status_q[2:0]);
    endproperty
    a_other_addr: assert property (p_other_addr) else $error("other address wrote status");

    property p_sleep_to;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (SLEEP_EXEC && !WATCHDOG_KICK && !WATCHDOG_TIMEOUT) |=> status_q[BIT_TO];
    endproperty
    a_sleep_to: assert property (p_sleep_to) else $error("sleep left timeout clear");

    property p_add_result;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_ADD) |=> RESULT == 8'($past(OPERAND_A) + $past(OPERAND_B));
    endproperty
    a_add_result: assert property (p_add_result) else $error("sum result wrong");

    property p_logic_zero;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_LOGIC_Z)
            |=> status_q[BIT_ZERO] == ($past(OPERAND_A) == 8'h00);
    endproperty
    a_logic_zero: assert property (p_logic_zero) else $error("logic zero flag wrong");

    property p_sub_zero;
        @(posedge CORE_CLK) disable iff (!rst_sync_q)
        (EXEC_VALID && ALU_OP == OP_SUB)
            |=> status_q[BIT_ZERO] == ($past(OPERAND_A) == $past(OPERAND_B));
    endproperty
    a_sub_zero: assert property (p_sub_zero) else $error("subtract zero flag wrong");

    c_clear: cover property (@(posedge CORE_CLK) hit && ALU_OP == OP_CLEAR);
    c_sub: cover property (@(posedge CORE_CLK) EXEC_VALID && ALU_OP == OP_SUB);
    c_sleep: cover property (@(posedge CORE_CLK) SLEEP_EXEC);
    c_kick_timeout: cover property (@(posedge CORE_CLK) WATCHDOG_KICK && WATCHDOG_TIMEOUT);
    c_flag_dest: cover property (@(posedge CORE_CLK) hit && ALU_OP == OP_ADD);
endmodule

/* File: logic/status_pkg.sv */
package status_pkg;
    localparam logic [8:0] STATUS_ADDR_BANK0 = 9'h0_003;
    localparam logic [8:0] STATUS_ADDR_BANK1 = 9'h0_083;
    localparam int BIT_CARRY = 0;
    localparam int BIT_NIBBLE = 1;
    localparam int BIT_ZERO = 2;
    localparam int BIT_PD = 3;
    localparam int BIT_TO = 4;
    localparam int BIT_RP_LO = 5;
    localparam int BIT_RP_HI = 6;
    localparam int BIT_IRP = 7;
    localparam logic [7:0] STATUS_RESET = 8'h0_018;
    localparam logic [8:0] BANK_SIZE = 9'h0_080;
    localparam logic [8:0] IND_HALF = 9'h0_100;
    localparam logic [2:0] FLAG_WRITE_MASK = 3'h0_7;
    typedef enum logic [3:0] {
        OP_NONE = 4'b0000,
        OP_MOVE = 4'b0001,
        OP_CLEAR = 4'b0010,
        OP_BIT_CLEAR = 4'b0011,
        OP_BIT_SET = 4'b0100,
        OP_SWAP = 4'b0101,
        OP_ADD = 4'b0110,
        OP_SUB = 4'b0111,
        OP_ROT_RIGHT = 4'b1000,
        OP_ROT_LEFT = 4'b1001,
        OP_LOGIC_Z = 4'b1010
    } alu_op_t;
endpackage

/* File: logic/alu_flag_calc.sv */
`timescale 1ns/1ps
module alu_flag_calc (
    // Operation and operands
    input wire status_pkg::alu_op_t op,
    input wire logic [7:0] opnd_a,
    input wire logic [7:0] opnd_b,
    input wire logic carry_in,
    // Results
    output logic [7:0] result,
    output logic [2:0] flags,
    output logic [2:0] flag_en
);
    import status_pkg::*;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] addend;
    always_comb begin
        addend = (op == OP_SUB) ? ~opnd_b : opnd_b;
        sum = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, op == OP_SUB};
        low = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, op == OP_SUB};
        result = opnd_a;
        flags = 3'b000;
        flag_en = 3'b000;
        case (op)
            OP_ADD, OP_SUB: begin
                result = sum[7:0];
                flags[0] = sum[8];
                flags[1] = low[4];
                flags[2] = (sum[7:0] == 8'h00);
                flag_en = FLAG_WRITE_MASK;
            end
            OP_ROT_RIGHT: begin
                result = {carry_in, opnd_a[7:1]};
                flags[0] = opnd_a[0];
                flag_en = 3'b001;
            end
            OP_ROT_LEFT: begin
                result = {opnd_a[6:0], carry_in};
                flags[0] = opnd_a[7];
                flag_en = 3'b001;
            end
            OP_LOGIC_Z: begin
                result = opnd_a;
                flags[2] = (opnd_a == 8'h00);
                flag_en = 3'b100;
            end
            OP_CLEAR: begin
                result = 8'h00;
                flags[2] = 1'b1;
                flag_en = 3'b100;
            end
            default: begin
                result = opnd_a;
            end
        endcase
    end
endmodule

/* File: tb/exec_core_model.sv */
`timescale 1ns/1ps
module exec_core_model (
    // Clock
    input wire logic clk,
    // Instruction drive
    output status_pkg::alu_op_t op,
    output logic exec_valid,
    output logic [8:0] dest,
    output logic dest_is_reg,
    output logic [7:0] opa,
    output logic [7:0] opb,
    output logic [2:0] bit_sel,
    // Power events
    output logic [2:0] pwr
);
    import status_pkg::*;
    initial begin
        op = OP_NONE;
        exec_valid = 1'b0;
        dest = 9'h0_000;
        dest_is_reg = 1'b0;
        opa = 8'h00;
        opb = 8'h00;
        bit_sel = 3'h0;
        pwr = 3'h0;
    end
    // One instruction for one cycle, then operands scrambled
    task automatic issue(input alu_op_t o, input logic [8:0] d, input logic r,
                         input logic [7:0] a, input logic [7:0] b, input logic [2:0] s);
        @(negedge clk);
        op = o;
        dest = d;
        dest_is_reg = r;
        opa = a;
        opb = b;
        bit_sel = s;
        exec_valid = 1'b1;
        @(negedge clk);
        exec_valid = 1'b0;
        opa = ~opa;
        opb = ~opb;
    endtask
    // Power pulses as kick, sleep, timeout
    task automatic power(input logic [2:0] p);
        @(negedge clk);
        pwr = p;
        @(negedge clk);
        pwr = 3'h0;
    endtask
endmodule

/* File: tb/alu_status_flags_bank_select_bench.sv */
`timescale 1ns/1ps
module alu_status_flags_bank_select_bench;
    import status_pkg::*;
    logic clk;
    logic rst_n;
    alu_op_t op;
    logic ev;
    logic dr;
    logic [2:0] pwr;
    logic [8:0] dest;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] st;
    logic [7:0] res;
    logic [2:0] bs;
    logic [8:0] daddr;
    logic [8:0] iaddr;
    int failures;
    int n_checks;
    localparam logic [6:0] OFS = 7'h05;
    localparam logic [7:0] PTR = 8'h3c;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    exec_core_model u_core (.clk(clk), .op(op), .exec_valid(ev), .dest(dest),
        .dest_is_reg(dr), .opa(a), .opb(b), .bit_sel(bs), .pwr(pwr));
    status_flags u_dut (.CORE_CLK(clk), .RST_N(rst_n), .EXEC_VALID(ev), .ALU_OP(op),
        .DEST_ADDR(dest), .DEST_IS_REG(dr), .OPERAND_A(a), .OPERAND_B(b), .BIT_SEL(bs),
        .WATCHDOG_KICK(pwr[2]), .SLEEP_EXEC(pwr[1]), .WATCHDOG_TIMEOUT(pwr[0]),
        .DIRECT_OFFSET(OFS), .INDIRECT_PTR(PTR), .STATUS_VALUE(st), .RESULT(res),
        .DIRECT_ADDR(daddr), .INDIRECT_ADDR(iaddr));
    task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic ex(input alu_op_t o, input logic [8:0] d, input logic r,
                      input logic [7:0] x, input logic [7:0] y, input logic [2:0] s,
                      input logic [7:0] e);
        u_core.issue(o, d, r, x, y, s);
        chk("status", {1'b0, st}, {1'b0, e});
    endtask
    task automatic pw(input logic [2:0] p, input logic [7:0] e);
        u_core.power(p);
        chk("status", {1'b0, st}, {1'b0, e});
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk("status", {1'b0, st}, 9'h0_018);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end
    initial begin
        rst_n = 1'b0;
        failures = 0;
        n_checks = 0;
        do_reset();
        ex(OP_ADD, 9'h0_020, 1'b0, 8'hff, 8'h01, 3'h0, 8'h1f);
        chk("result", {1'b0, res}, 9'h0_000);
        ex(OP_SUB, 9'h0_020, 1'b0, 8'h10, 8'h01, 3'h0, 8'h19);
        chk("result", {1'b0, res}, 9'h0_00f);
        ex(OP_SUB, 9'h0_020, 1'b0, 8'h00, 8'h01, 3'h0, 8'h18);
        ex(OP_ROT_RIGHT, 9'h0_020, 1'b0, 8'h01, 8'h00, 3'h0, 8'h19);
        chk("result", {1'b0, res}, 9'h0_000);
        ex(OP_ROT_LEFT, 9'h0_020, 1'b0, 8'h7f, 8'h00, 3'h0, 8'h18);
        chk("result", {1'b0, res}, 9'h0_0ff);
        ex(OP_LOGIC_Z, 9'h0_020, 1'b0, 8'h00, 8'h00, 3'h0, 8'h1c);
        ex(OP_LOGIC_Z, 9'h0_020, 1'b0, 8'h05, 8'h00, 3'h0, 8'h18);
        ex(OP_SUB, 9'h0_020, 1'b0, 8'h25, 8'h10, 3'h0, 8'h1b);
        chk("result", {1'b0, res}, 9'h0_015);
        ex(OP_MOVE, STATUS_ADDR_BANK0, 1'b1, 8'he3, 8'h00, 3'h0, 8'hfb);
        chk("direct", daddr, {2'b11, OFS});
        chk("indirect", iaddr, {1'b1, PTR});
        ex(OP_CLEAR, STATUS_ADDR_BANK1, 1'b1, 8'h00, 8'h00, 3'h0, 8'h1f);
        ex(OP_MOVE, STATUS_ADDR_BANK1, 1'b1, 8'h00, 8'h00, 3'h0, 8'h18);
        ex(OP_ADD, STATUS_ADDR_BANK0, 1'b1, 8'he0, 8'h03, 3'h0, 8'hf8);
        ex(OP_MOVE, 9'h0_020, 1'b1, 8'h00, 8'h00, 3'h0, 8'hf8);
        ex(OP_BIT_CLEAR, STATUS_ADDR_BANK1, 1'b1, 8'hf8, 8'h00, 3'h4, 8'hf8);
        ex(OP_BIT_CLEAR, STATUS_ADDR_BANK1, 1'b1, 8'hf8, 8'h00, 3'h7, 8'h78);
        ex(OP_SWAP, STATUS_ADDR_BANK0, 1'b1, 8'h78, 8'h00, 3'h0, 8'h9f);
        ex(OP_BIT_SET, STATUS_ADDR_BANK0, 1'b1, 8'h18, 8'h00, 3'h5, 8'h38);
        for (int i = 0; i < 4; i++) begin
            ex(OP_MOVE, STATUS_ADDR_BANK0, 1'b1, {1'b0, i[1:0], 5'h00}, 8'h00, 3'h0,
               {1'b0, i[1:0], 5'h18});
            chk("direct", daddr, BANK_SIZE * i[1:0] + {2'b00, OFS});
            chk("indirect", iaddr, {1'b0, PTR});
        end
        ex(OP_CLEAR, STATUS_ADDR_BANK0, 1'b1, 8'h00, 8'h00, 3'h0, 8'h1c);
        pw(3'b010, 8'h14);
        pw(3'b001, 8'h04);
        pw(3'b100, 8'h1c);
        pw(3'b101, 8'h0c);
        pw(3'b110, 8'h1c);
        pw(3'b010, 8'h14);
        ex(OP_MOVE, STATUS_ADDR_BANK0, 1'b1, 8'hff, 8'h00, 3'h0, 8'hf7);
        do_reset();
        tally_and_finish();
    end
endmodule
